// ### core/cda_defines.vh
// Constants of the CPU data addressing, ALU and flag slice.
// Assumes inclusion by bare name from every design file of the slice.
//
// How it works
// - Two data planes; second plane reached only by W-to-plane and plane-to-W moves.
// - Primary plane address 00 holds nothing; it reaches the primary pointer's target.
// - Primary pointer lives at 04, resets to 00, read-write, gives indirect target.
// - Second plane can also be reached indirectly through the primary pointer.
// - Bit set and clear at direct addresses work only in the lower half of the primary plane.
// - Low primary addresses are special registers, banked RAM sits above them.
// - Second plane address 00 is a virtual port through the secondary pointer.
// - Secondary pointer lives at second plane 05, eight bits, resets to 00.
// - Second plane 08..0F are read-only registers, plain RAM above.
// - Eight-bit ALU adds, subtracts, shifts and does logic between W and a file.
// - Zero flag, status bit 2, set on zero result of flag-affecting operations other than the rotates.
// - Digit carry, bit 1: nibble carry on add, inverted nibble borrow on subtract.
// - Carry, bit 0: carry out on add, inverted borrow on subtract.
// - W is an eight-bit operand register with no address in either plane.
// - Autosave enable, second plane 07 bit 5, saves W on entry, restores on exit.
// - The same enable saves and restores the status register.
// - Flag-affecting writes to status keep the flag logic result in bits 2..0.
// - Bit clear, bit set and move W to file change status flags directly.
// - Status lives at 03, resets to 00, holds flags, page and bank bits.
// - Status bit 6 selects program page 0 or page 1.
// - Status bit 5 selects RAM bank 0 or bank 1 for primary plane RAM accesses.
`ifndef CDA_DEFINES_VH
`define CDA_DEFINES_VH

// ======================================================
// Primary plane map
`define CDA_F_IND_PORT 8'h00
`define CDA_F_STATUS 8'h03
`define CDA_F_PTR 8'h04
`define CDA_F_RAM_BASE 8'h20
`define CDA_F_PTR_RST 8'h00

// ======================================================
// Second plane map
`define CDA_R_IND_PORT 8'h00
`define CDA_R_PTR 8'h05
`define CDA_R_CLK_CTRL 8'h07
`define CDA_R_RO_BASE 8'h08
`define CDA_R_RAM_BASE 8'h10
`define CDA_R_PTR_RST 8'h00
`define CDA_R_CLK_RST 8'h18
`define CDA_R_CLK_MASK 8'h3F
`define CDA_AUTOSAVE_BIT 5

// ======================================================
// Status layout
`define CDA_STATUS_RST 8'h00
`define CDA_STATUS_MASK 8'h67
`define CDA_ST_C 0
`define CDA_ST_DC 1
`define CDA_ST_Z 2
`define CDA_ST_BANK 5
`define CDA_ST_PAGE 6

// ======================================================
// Operation codes
`define CDA_OP_ADD 5'h00
`define CDA_OP_SUB 5'h01
`define CDA_OP_AND 5'h02
`define CDA_OP_IOR 5'h03
`define CDA_OP_XOR 5'h04
`define CDA_OP_RLF 5'h05
`define CDA_OP_RRF 5'h06
`define CDA_OP_INC 5'h07
`define CDA_OP_DEC 5'h08
`define CDA_OP_COM 5'h09
`define CDA_OP_MOVF 5'h0A
`define CDA_OP_MOVWF 5'h0B
`define CDA_OP_CLR 5'h0C
`define CDA_OP_BCF 5'h0D
`define CDA_OP_BSF 5'h0E
`define CDA_OP_MOVLW 5'h0F
`define CDA_OP_MOVWR 5'h10
`define CDA_OP_MOVE_SECOND_PLANE_TO_W 5'h11
`define CDA_OP_MOVWRI 5'h12
`define CDA_OP_MOVRWI 5'h13

`endif

// ### core/cda_alu.v
// Eight-bit ALU of the slice, purely combinational.
// Assumes the caller picks the destination and applies the flag enables.
`timescale 1ns/100ps
`include "cda_defines.vh"

module cda_alu (
   input wire [4:0] op,
   input wire [7:0] file_val,
   input wire [7:0] w_val,
   input wire [2:0] bit_sel,
   input wire carry_in,
   output reg [7:0] result,
   output reg z_out,
   output reg dc_out,
   output reg c_out,
   output reg z_en,
   output reg dc_en,
   output reg c_en
);

   // ======================================================
   // Adders
   // Subtract as f + ~W + 1 so carry out is the inverted borrow
   wire [8:0] add_sum;
   wire [8:0] sub_sum;
   wire [4:0] add_nib;
   wire [4:0] sub_nib;
   wire [7:0] bit_mask;

   assign add_sum = {1'b0, file_val} + {1'b0, w_val};
   assign sub_sum = {1'b0, file_val} + {1'b0, ~w_val} + 9'h001;
   assign add_nib = {1'b0, file_val[3:0]} + {1'b0, w_val[3:0]};
   assign sub_nib = {1'b0, file_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
   assign bit_mask = 8'h01 << bit_sel;

   // ======================================================
   // Operation select
   always @* begin
      result = file_val;
      dc_out = 1'b0;
      c_out = 1'b0;
      z_en = 1'b0;
      dc_en = 1'b0;
      c_en = 1'b0;
      case (op)
         `CDA_OP_ADD: begin
            result = add_sum[7:0];
            dc_out = add_nib[4];
            c_out = add_sum[8];
            z_en = 1'b1;
            dc_en = 1'b1;
            c_en = 1'b1;
         end
         `CDA_OP_SUB: begin
            result = sub_sum[7:0];
            dc_out = sub_nib[4];
            c_out = sub_sum[8];
            z_en = 1'b1;
            dc_en = 1'b1;
            c_en = 1'b1;
         end
         `CDA_OP_AND: begin
            result = file_val & w_val;
            z_en = 1'b1;
         end
         `CDA_OP_IOR: begin
            result = file_val | w_val;
            z_en = 1'b1;
         end
         `CDA_OP_XOR: begin
            result = file_val ^ w_val;
            z_en = 1'b1;
         end
         `CDA_OP_RLF: begin
            result = {file_val[6:0], carry_in};
            c_out = file_val[7];
            c_en = 1'b1;
         end
         `CDA_OP_RRF: begin
            result = {carry_in, file_val[7:1]};
            c_out = file_val[0];
            c_en = 1'b1;
         end
         `CDA_OP_INC: begin
            result = file_val + 8'h01;
            z_en = 1'b1;
         end
         `CDA_OP_DEC: begin
            result = file_val - 8'h01;
            z_en = 1'b1;
         end
         `CDA_OP_COM: begin
            result = ~file_val;
            z_en = 1'b1;
         end
         `CDA_OP_MOVF: begin
            z_en = 1'b1;
         end
         `CDA_OP_CLR: begin
            result = 8'h00;
            z_en = 1'b1;
         end
         `CDA_OP_BCF: result = file_val & ~bit_mask;
         `CDA_OP_BSF: result = file_val | bit_mask;
         `CDA_OP_MOVWF: result = w_val;
         `CDA_OP_MOVWR: result = w_val;
         `CDA_OP_MOVWRI: result = w_val;
         default: result = file_val;
      endcase
      z_out = (result == 8'h00);
   end

endmodule

// ### core/cda_core.v
// Data addressing, working register and status flags of the CPU core.
// Assumes a sequencer that presents one decoded instruction per valid cycle
// and one-cycle interrupt entry and exit pulses, all on clk.
`timescale 1ns/100ps
`include "cda_defines.vh"

module cda_core #(
   parameter RO_COUNT = 8
) (
   input wire clk,
   input wire arst_n,
   input wire instr_valid,
   input wire [4:0] instr_op,
   input wire [7:0] instr_addr,
   input wire [2:0] instr_bit,
   input wire instr_to_file,
   input wire [7:0] instr_literal,
   input wire irq_enter,
   input wire irq_exit,
   input wire [8*RO_COUNT-1:0] ro_regs_in,
   output wire [7:0] w_out,
   output wire [7:0] status_out,
   output wire rom_page_sel,
   output wire ram_bank_sel,
   output wire [7:0] clk_ctrl_out,
   output wire [7:0] result_out,
   output wire done_pulse,
   output wire reject_pulse
);

   // ======================================================
   // State
   // W has no plane address; only the ALU, moves and autosave restore reach it
   reg [7:0] w_r;
   reg [7:0] status_r;
   reg [7:0] fptr_r;
   reg [7:0] rptr_r;
   reg [7:0] clk_ctrl_r;
   reg [7:0] w_save_r;
   reg [7:0] status_save_r;
   reg [7:0] result_r;
   reg done_r;
   reg reject_r;
   reg [7:0] fmem [0:511];
   reg [7:0] rmem [0:255];

   reg [7:0] w_nxt;
   reg [7:0] status_nxt;
   reg [7:0] fptr_nxt;
   reg [7:0] rptr_nxt;
   reg [7:0] clk_ctrl_nxt;
   reg [7:0] w_save_nxt;
   reg [7:0] status_save_nxt;

   // ======================================================
   // Decode
   wire op_r_store;
   wire op_r_load;
   wire op_r_via_f;
   wire op_r_plane;
   wire op_bit;
   wire op_lit;
   wire irq_cycle;
   wire exec;

   assign op_r_store = (instr_op == `CDA_OP_MOVWR) || (instr_op == `CDA_OP_MOVWRI);
   assign op_r_load = (instr_op == `CDA_OP_MOVE_SECOND_PLANE_TO_W) || (instr_op == `CDA_OP_MOVRWI);
   assign op_r_via_f = (instr_op == `CDA_OP_MOVWRI) || (instr_op == `CDA_OP_MOVRWI);
   assign op_r_plane = op_r_store || op_r_load;
   assign op_bit = (instr_op == `CDA_OP_BCF) || (instr_op == `CDA_OP_BSF);
   assign op_lit = (instr_op == `CDA_OP_MOVLW);
   assign irq_cycle = irq_enter || irq_exit;
   assign exec = instr_valid && !irq_cycle;

   // Direct bit addressing stops at the plane midpoint
   wire bit_reject;
   assign bit_reject = op_bit && instr_addr[7];

   // ======================================================
   // Primary plane addressing
   wire f_ind;
   wire [7:0] f_ea;
   wire f_self;
   wire f_ram;
   wire [8:0] f_idx;

   assign f_ind = (instr_addr == `CDA_F_IND_PORT);
   assign f_ea = f_ind ? fptr_r : instr_addr;
   assign f_self = f_ind && (fptr_r == `CDA_F_IND_PORT);
   assign f_ram = (f_ea >= `CDA_F_RAM_BASE);
   assign f_idx = {f_ram & status_r[`CDA_ST_BANK], f_ea};

   reg [7:0] f_rd;
   always @* begin
      f_rd = 8'h00;
      if (!f_self) begin
         case (f_ea)
            `CDA_F_STATUS: f_rd = status_r & `CDA_STATUS_MASK;
            `CDA_F_PTR: f_rd = fptr_r;
            default: f_rd = fmem[f_idx];
         endcase
      end
   end

   // ======================================================
   // Second plane addressing
   wire r_ind;
   wire [7:0] r_ea;
   wire r_self;
   wire r_ro;
   wire [7:0] r_ro_off;

   assign r_ind = op_r_via_f || (instr_addr == `CDA_R_IND_PORT);
   assign r_ea = op_r_via_f ? fptr_r : (r_ind ? rptr_r : instr_addr);
   assign r_self = r_ind && (r_ea == `CDA_R_IND_PORT);
   assign r_ro = (r_ea >= `CDA_R_RO_BASE) && (r_ea < `CDA_R_RAM_BASE);
   assign r_ro_off = r_ea - `CDA_R_RO_BASE;

   reg [7:0] r_rd;
   always @* begin
      r_rd = 8'h00;
      if (!r_self) begin
         if (r_ea == `CDA_R_PTR) begin
            r_rd = rptr_r;
         end else if (r_ea == `CDA_R_CLK_CTRL) begin
            r_rd = 8'h00;
         end else if (r_ro) begin
            if (r_ro_off < RO_COUNT) begin
               r_rd = ro_regs_in[r_ro_off*8 +: 8];
            end
         end else begin
            r_rd = rmem[r_ea];
         end
      end
   end

   // ======================================================
   // ALU
   wire [7:0] alu_res;
   wire alu_z;
   wire alu_dc;
   wire alu_c;
   wire alu_z_en;
   wire alu_dc_en;
   wire alu_c_en;

   cda_alu u_alu (
      .op(instr_op),
      .file_val(f_rd),
      .w_val(w_r),
      .bit_sel(instr_bit),
      .carry_in(status_r[`CDA_ST_C]),
      .result(alu_res),
      .z_out(alu_z),
      .dc_out(alu_dc),
      .c_out(alu_c),
      .z_en(alu_z_en),
      .dc_en(alu_dc_en),
      .c_en(alu_c_en)
   );

   // ======================================================
   // Write enables
   wire f_dest;
   wire f_we;
   wire w_we;
   wire r_we;
   wire [7:0] w_src;

   // Bit ops and W-to-file always land in the file
   assign f_dest = op_bit || (instr_op == `CDA_OP_MOVWF) ||
                   (instr_to_file && !op_lit && !op_r_plane);
   assign f_we = exec && f_dest && !f_self && !bit_reject;
   assign w_we = exec && (op_lit || op_r_load || (!f_dest && !op_r_plane));
   assign r_we = exec && op_r_store && !r_self && !r_ro;
   assign w_src = op_lit ? instr_literal : (op_r_load ? r_rd : alu_res);

   wire flag_upd;
   assign flag_upd = exec && !op_r_plane && !op_lit && !bit_reject;

   // ======================================================
   // Destination decode
   // One compare per special register keeps the next-state logic flat
   wire f_to_status;
   wire f_to_ptr;
   wire r_to_ptr;
   wire r_to_clk;
   wire flag_op;
   wire autosave_on;

   assign f_to_status = f_we && (f_ea == `CDA_F_STATUS);
   assign f_to_ptr = f_we && (f_ea == `CDA_F_PTR);
   assign r_to_ptr = r_we && (r_ea == `CDA_R_PTR);
   assign r_to_clk = r_we && (r_ea == `CDA_R_CLK_CTRL);
   assign flag_op = flag_upd && (alu_z_en || alu_dc_en || alu_c_en);
   assign autosave_on = clk_ctrl_r[`CDA_AUTOSAVE_BIT];

   // ======================================================
   // Next state
   always @* begin
      w_nxt = w_r;
      status_nxt = status_r;
      fptr_nxt = fptr_r;
      rptr_nxt = rptr_r;
      clk_ctrl_nxt = clk_ctrl_r;
      w_save_nxt = w_save_r;
      status_save_nxt = status_save_r;
      if (irq_enter && autosave_on) begin
         w_save_nxt = w_r;
         status_save_nxt = status_r;
      end else if (irq_exit && autosave_on) begin
         w_nxt = w_save_r;
         status_nxt = status_save_r;
      end else begin
         if (w_we) begin
            w_nxt = w_src;
         end
         if (f_to_status) begin
            status_nxt = alu_res & `CDA_STATUS_MASK;
         end
         if (f_to_ptr) begin
            fptr_nxt = alu_res;
         end
         if (r_to_ptr) begin
            rptr_nxt = alu_res;
         end
         if (r_to_clk) begin
            clk_ctrl_nxt = alu_res & `CDA_R_CLK_MASK;
         end
         // Flag logic applied last so it beats any destination write
         if (flag_op && f_to_status) begin
            status_nxt[`CDA_ST_Z] = status_r[`CDA_ST_Z];
            status_nxt[`CDA_ST_DC] = status_r[`CDA_ST_DC];
            status_nxt[`CDA_ST_C] = status_r[`CDA_ST_C];
         end
         if (flag_upd && alu_z_en) begin
            status_nxt[`CDA_ST_Z] = alu_z;
         end
         if (flag_upd && alu_dc_en) begin
            status_nxt[`CDA_ST_DC] = alu_dc;
         end
         if (flag_upd && alu_c_en) begin
            status_nxt[`CDA_ST_C] = alu_c;
         end
      end
   end

   // ======================================================
   // Registers
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         w_r <= 8'h00;
         status_r <= `CDA_STATUS_RST;
         fptr_r <= `CDA_F_PTR_RST;
         rptr_r <= `CDA_R_PTR_RST;
         clk_ctrl_r <= `CDA_R_CLK_RST;
         w_save_r <= 8'h00;
         status_save_r <= 8'h00;
         result_r <= 8'h00;
         done_r <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         w_r <= w_nxt;
         status_r <= status_nxt;
         fptr_r <= fptr_nxt;
         rptr_r <= rptr_nxt;
         clk_ctrl_r <= clk_ctrl_nxt;
         w_save_r <= w_save_nxt;
         status_save_r <= status_save_nxt;
         done_r <= exec;
         reject_r <= exec && bit_reject;
         if (exec) begin
            result_r <= op_r_load ? r_rd : (op_lit ? instr_literal : alu_res);
         end
      end
   end

   // ======================================================
   // Storage arrays
   // Arrays carry no reset; software must initialise RAM before use
   wire f_mem_we;
   wire r_mem_we;
   // Special registers live outside the arrays
   assign f_mem_we = f_we && !f_to_status && !f_to_ptr;
   assign r_mem_we = r_we && !r_to_ptr && !r_to_clk;

   always @(posedge clk) begin
      if (f_mem_we) begin
         fmem[f_idx] <= alu_res;
      end
      if (r_mem_we) begin
         rmem[r_ea] <= alu_res;
      end
   end

   // ======================================================
   // Outputs
   assign w_out = w_r;
   assign status_out = status_r;
   assign rom_page_sel = status_r[`CDA_ST_PAGE];
   assign ram_bank_sel = status_r[`CDA_ST_BANK];
   assign clk_ctrl_out = clk_ctrl_r;
   assign result_out = result_r;
   assign done_pulse = done_r;
   assign reject_pulse = reject_r;

endmodule

// ### verif/cda_core_chk.sv
// Checker of the data slice: pulses, flags, status layout and autosave.
// Assumes a bind onto cda_core; it sees the top ports only.
`timescale 1ns/100ps
`include "cda_defines.vh"
module cda_core_chk #(
   parameter RO_COUNT = 8
) (
   input wire clk,
   input wire arst_n,
   input wire instr_valid,
   input wire [4:0] instr_op,
   input wire [7:0] instr_addr,
   input wire instr_to_file,
   input wire [7:0] instr_literal,
   input wire irq_enter,
   input wire irq_exit,
   input wire [7:0] w_out,
   input wire [7:0] status_out,
   input wire rom_page_sel,
   input wire ram_bank_sel,
   input wire [7:0] clk_ctrl_out,
   input wire [7:0] result_out,
   input wire done_pulse,
   input wire reject_pulse
);
// ==========================================
// Helpers
wire take = instr_valid && !irq_enter && !irq_exit;
wire bitop = take && (instr_op == `CDA_OP_BCF || instr_op == `CDA_OP_BSF);
reg [7:0] sv_w_r;
reg [7:0] sv_st_r;
// One shadow only, so nesting is out of scope
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      sv_w_r <= 8'h00;
      sv_st_r <= 8'h00;
   end else if (irq_enter && clk_ctrl_out[`CDA_AUTOSAVE_BIT]) begin
      sv_w_r <= w_out;
      sv_st_r <= status_out;
   end
end
default clocking cb @(posedge clk); endclocking
default disable iff (!arst_n);
// ==========================================
// Assertions
a_done_after_take: assert property (take |=> done_pulse)
   else $error("done missing");
a_no_spurious_done: assert property (!take |=> !done_pulse)
   else $error("done without instruction");
a_reject_upper: assert property (bitop && instr_addr[7] |=> reject_pulse && $stable(status_out))
   else $error("upper half bit op not refused");
a_bit_keeps_flags: assert property (bitop && instr_addr > 8'h04 |=> $stable(status_out))
   else $error("bit op changed status");
a_literal_load: assert property (take && instr_op == `CDA_OP_MOVLW
   |=> w_out == $past(instr_literal) && result_out == w_out && $stable(status_out))
   else $error("literal load wrong");
a_zero_flag: assert property (take && !instr_to_file && instr_op <= `CDA_OP_SUB
   |=> status_out[`CDA_ST_Z] == (w_out == 8'h00))
   else $error("zero flag wrong");
a_page_mirror: assert property (take && instr_op == `CDA_OP_MOVWF
   && instr_addr == `CDA_F_STATUS |=> rom_page_sel == $past(w_out[`CDA_ST_PAGE]))
   else $error("page select mismatch");
a_bank_mirror: assert property (take && instr_op == `CDA_OP_MOVWF
   && instr_addr == `CDA_F_STATUS |=> ram_bank_sel == $past(w_out[`CDA_ST_BANK]))
   else $error("bank select mismatch");
a_status_unused: assert property ((status_out & 8'h98) == 8'h00)
   else $error("unused status bits set");
a_irq_restore: assert property (irq_exit && !irq_enter && clk_ctrl_out[`CDA_AUTOSAVE_BIT]
   |=> w_out == sv_w_r && status_out == sv_st_r)
   else $error("autosave restore wrong");
c_reject: cover property (reject_pulse);
c_restore: cover property (irq_exit && clk_ctrl_out[`CDA_AUTOSAVE_BIT]);
c_borrow: cover property (take && instr_op == `CDA_OP_SUB ##1 !status_out[`CDA_ST_C]);
endmodule
bind cda_core cda_core_chk #(.RO_COUNT(RO_COUNT)) cda_core_chk_i (
   .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_op(instr_op),
   .instr_addr(instr_addr), .instr_to_file(instr_to_file), .instr_literal(instr_literal),
   .irq_enter(irq_enter), .irq_exit(irq_exit), .w_out(w_out), .status_out(status_out),
   .rom_page_sel(rom_page_sel), .ram_bank_sel(ram_bank_sel), .clk_ctrl_out(clk_ctrl_out),
   .result_out(result_out), .done_pulse(done_pulse), .reject_pulse(reject_pulse));

// ### verif/tb_top.sv
// Self-checking bench of the data slice, one task per scenario.
// Assumes cda_core with the checker bound; instructions one every two cycles.
`timescale 1ns/100ps
`include "cda_defines.vh"
module tb_top;
// ==========================================
// Stimulus and design
reg clk = 1'b0;
reg arst_n = 1'b0;
reg instr_valid = 1'b0;
reg [4:0] instr_op = 5'h00;
reg [7:0] instr_addr = 8'h00;
reg [2:0] instr_bit = 3'h0;
reg instr_to_file = 1'b0;
reg [7:0] instr_literal = 8'h00;
reg irq_enter = 1'b0;
reg irq_exit = 1'b0;
reg [7:0] k;
wire [63:0] ro_regs_in = 64'h8786858483828180;
wire [7:0] w_out, status_out, clk_ctrl_out, result_out;
wire rom_page_sel, ram_bank_sel, done_pulse, reject_pulse;
int n_fail = 0;
int checks_done = 0;
always #5 clk = ~clk;
cda_core #(.RO_COUNT(8)) cda_core_i (
   .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_op(instr_op),
   .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_to_file(instr_to_file),
   .instr_literal(instr_literal), .irq_enter(irq_enter), .irq_exit(irq_exit),
   .ro_regs_in(ro_regs_in), .w_out(w_out), .status_out(status_out),
   .rom_page_sel(rom_page_sel), .ram_bank_sel(ram_bank_sel), .clk_ctrl_out(clk_ctrl_out),
   .result_out(result_out), .done_pulse(done_pulse), .reject_pulse(reject_pulse));
// ==========================================
// Shared tasks
task automatic chk(input [7:0] seen, input [7:0] exp);
   checks_done++;
   if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
   end
endtask
task automatic complete_run;
   $display("checks %0d mismatches %0d", checks_done, n_fail);
   if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
   else $display("MISMATCHES SEEN");
   $finish;
endtask
// Valid drops between instructions, so no strobe is set twice per step
task automatic run(input [4:0] op, input [7:0] a, input tf, input [7:0] lit);
   @(posedge clk);
   instr_op <= op;
   instr_addr <= a;
   instr_to_file <= tf;
   instr_literal <= lit;
   instr_bit <= lit[2:0];
   instr_valid <= 1'b1;
   @(posedge clk);
   instr_valid <= 1'b0;
   #1;
endtask
task automatic ld(input [7:0] v); run(`CDA_OP_MOVLW, 8'h00, 1'b0, v); endtask
task automatic wr(input [7:0] a); run(`CDA_OP_MOVWF, a, 1'b1, 8'h00); endtask
task automatic rd(input [7:0] a, input [7:0] exp);
   run(`CDA_OP_MOVF, a, 1'b0, 8'h00);
   chk(w_out, exp);
endtask
task automatic rr(input [7:0] a, input [7:0] exp);
   run(`CDA_OP_MOVE_SECOND_PLANE_TO_W, a, 1'b0, 8'h00);
   chk(w_out, exp);
endtask
task automatic alu(input [4:0] op, input [7:0] f, w, res, flg, msk);
   ld(f);
   wr(8'h30);
   ld(w);
   run(op, 8'h30, 1'b0, 8'h00);
   chk(w_out, res);
   chk(status_out & msk, flg);
endtask
// Instruction in the pulse cycle must be dropped
task automatic irq(input en, input ex);
   @(posedge clk);
   irq_enter <= en;
   irq_exit <= ex;
   instr_op <= `CDA_OP_MOVLW;
   instr_literal <= 8'h99;
   instr_valid <= 1'b1;
   @(posedge clk);
   irq_enter <= 1'b0;
   irq_exit <= 1'b0;
   instr_valid <= 1'b0;
   #1;
   chk({7'h00, done_pulse}, 8'h00);
endtask
// ==========================================
// Scenarios
task automatic t_reset;
   chk(status_out, 8'h00);
   chk(clk_ctrl_out, 8'h18);
   rd(8'h04, 8'h00);
   rr(8'h05, 8'h00);
endtask
task automatic t_indirect;
   ld(8'h30);
   wr(8'h04);
   ld(8'h12);
   wr(8'h00);
   ld(8'h00);
   rd(8'h30, 8'h12);
   rd(8'h00, 8'h12);
   rd(8'h04, 8'h30);
   ld(8'h00);
   wr(8'h04);
   ld(8'h55);
   wr(8'h00);
   rd(8'h00, 8'h00);
endtask
task automatic t_second;
   ld(8'hA5);
   run(`CDA_OP_MOVWR, 8'h20, 1'b0, 8'h00);
   rr(8'h00, 8'h00);
   ld(8'h00);
   rr(8'h20, 8'hA5);
   ld(8'h20);
   run(`CDA_OP_MOVWR, 8'h05, 1'b0, 8'h00);
   rr(8'h00, 8'hA5);
   rr(8'h05, 8'h20);
   wr(8'h04);
   ld(8'h77);
   run(`CDA_OP_MOVWRI, 8'h00, 1'b0, 8'h00);
   rr(8'h20, 8'h77);
   ld(8'h00);
   run(`CDA_OP_MOVRWI, 8'h00, 1'b0, 8'h00);
   chk(w_out, 8'h77);
   for (k = 8'h00; k < 8'h08; k++) rr(8'h08 + k, 8'h80 + k);
   ld(8'hFF);
   run(`CDA_OP_MOVWR, 8'h09, 1'b0, 8'h00);
   rr(8'h09, 8'h81);
endtask
task automatic t_alu;
   alu(`CDA_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h02, 8'h07);
   alu(`CDA_OP_ADD, 8'h80, 8'h80, 8'h00, 8'h05, 8'h07);
   alu(`CDA_OP_SUB, 8'h10, 8'h01, 8'h0F, 8'h01, 8'h07);
   alu(`CDA_OP_SUB, 8'h01, 8'h02, 8'hFF, 8'h00, 8'h07);
   alu(`CDA_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h07, 8'h07);
   alu(`CDA_OP_RLF, 8'h81, 8'h00, 8'h03, 8'h01, 8'h01);
   alu(`CDA_OP_RRF, 8'h02, 8'h00, 8'h81, 8'h00, 8'h01);
   alu(`CDA_OP_AND, 8'h0F, 8'hF0, 8'h00, 8'h04, 8'h04);
   alu(`CDA_OP_IOR, 8'h50, 8'h0F, 8'h5F, 8'h00, 8'h04);
   alu(`CDA_OP_XOR, 8'hAA, 8'hAA, 8'h00, 8'h04, 8'h04);
   alu(`CDA_OP_INC, 8'hFF, 8'h00, 8'h00, 8'h04, 8'h04);
   alu(`CDA_OP_DEC, 8'h02, 8'h00, 8'h01, 8'h00, 8'h04);
   alu(`CDA_OP_COM, 8'h0F, 8'h00, 8'hF0, 8'h00, 8'h04);
   alu(`CDA_OP_MOVF, 8'h00, 8'h11, 8'h00, 8'h04, 8'h04);
   alu(`CDA_OP_CLR, 8'h33, 8'h11, 8'h00, 8'h04, 8'h04);
endtask
task automatic t_status;
   ld(8'h07);
   wr(8'h03);
   chk(status_out, 8'h07);
   ld(8'hFE);
   run(`CDA_OP_ADD, 8'h03, 1'b1, 8'h00);
   chk(result_out, 8'h05);
   chk(status_out, 8'h03);
   run(`CDA_OP_BSF, 8'h03, 1'b1, 8'h06);
   chk({7'h00, rom_page_sel}, 8'h01);
   run(`CDA_OP_BCF, 8'h03, 1'b1, 8'h00);
   chk(status_out, 8'h42);
   run(`CDA_OP_BSF, 8'h03, 1'b1, 8'h05);
   chk({7'h00, ram_bank_sel}, 8'h01);
   ld(8'h3C);
   wr(8'h40);
   run(`CDA_OP_BCF, 8'h03, 1'b1, 8'h05);
   ld(8'hC3);
   wr(8'h40);
   run(`CDA_OP_BSF, 8'h03, 1'b1, 8'h05);
   rd(8'h40, 8'h3C);
   run(`CDA_OP_BCF, 8'h03, 1'b1, 8'h05);
   rd(8'h40, 8'hC3);
   ld(8'h00);
   wr(8'h90);
   run(`CDA_OP_BSF, 8'h90, 1'b1, 8'h00);
   chk({7'h00, reject_pulse}, 8'h01);
   rd(8'h90, 8'h00);
endtask
task automatic t_autosave;
   ld(8'h11);
   irq(1'b1, 1'b0);
   ld(8'h22);
   irq(1'b0, 1'b1);
   chk(w_out, 8'h22);
   ld(8'h38);
   run(`CDA_OP_MOVWR, 8'h07, 1'b0, 8'h00);
   chk(clk_ctrl_out, 8'h38);
   ld(8'h41);
   wr(8'h03);
   ld(8'h11);
   irq(1'b1, 1'b0);
   ld(8'h22);
   wr(8'h03);
   irq(1'b0, 1'b1);
   chk(w_out, 8'h11);
   chk(status_out, 8'h41);
endtask
// Pointers were left non-zero, so the mid-run reset must clear them
task automatic t_rereset;
   @(posedge clk);
   arst_n <= 1'b0;
   @(posedge clk);
   #1;
   chk(status_out, 8'h00);
   chk(clk_ctrl_out, 8'h18);
   @(posedge clk);
   arst_n <= 1'b1;
   rd(8'h04, 8'h00);
   rr(8'h05, 8'h00);
endtask
// ==========================================
// Sequence and watchdog
initial begin
   repeat (5) @(posedge clk);
   arst_n <= 1'b1;
   t_reset;
   t_indirect;
   t_second;
   t_alu;
   t_status;
   t_autosave;
   t_rereset;
   complete_run;
end
initial begin
   repeat (20000) @(posedge clk);
   n_fail++;
   complete_run;
end
endmodule
